// file: logic/ibm_bus_mgmt.sv
// Controller-side management of a parallel instrument bus.
// Assumes a byte handshake engine outside takes bus bytes on out_valid
// and out_ready; bus lines ren, srq, ifc are pins.
`timescale 1ns/10ps

// Functional notes
// - Abort stops transfers and pulses interface clear.
// - Interface clear hits all; addresses selective.
// - Device clear only as active controller.
// - System controller asserts remote at reset, abort.
// - Lockout sent universally, active controller only.
// - Lockout survives abort; interface local cancels.
// - Local addressed selective; interface-wide needs system.
// - Remote refused unless system controller.
// - Trigger listeners, or address then trigger.
// - Abort needs active or system; regains active.
// - Abort with addresses is rejected.
// - Enabled service request raises interrupt while active controller.
// - Two interrupt classes: service, non-active events.
// - Attention true for commands, false for data.
// - Unlisten, talker, listeners, then data.
// - Service request is sampled as a level.
module ibm_bus_mgmt
    import ibm_pkg::*;
(
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic req_valid,
    output logic req_ready,
    input ibm_req_t req,
    input wire logic sys_ctl,
    input wire logic srq_en,
    input wire logic irq_ack,
    input wire logic ctl_event,
    input wire logic data_done,
    output ibm_byte_t out_byte,
    output logic out_valid,
    input wire logic out_ready,
    output logic ifc_o,
    output logic ren_o,
    input wire logic srq_pin,
    output ibm_stat_t status,
    output logic srq_irq,
    output logic nac_irq
);
    // ------------------------------------------------------------------
    // State and storage
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        IBM_IDLE, IBM_IFC, IBM_UNL, IBM_TALK, IBM_LISTEN, IBM_MSG, IBM_DATA
    } ibm_state_t;

    ibm_state_t state_ff, nxt_state;
    ibm_req_t req_ff, nxt_req;
    logic [3:0] idx_ff, nxt_idx;
    logic [`IBM_IFC_W-1:0] cnt_ff, nxt_cnt;
    logic active_ff, nxt_active;
    logic ren_ff, nxt_ren;
    logic lockout_ff, nxt_lockout;
    logic err_ff, nxt_err;
    logic done_ff, nxt_done;
    logic nac_ff, nxt_nac;
    ibm_byte_t byte_ff, nxt_byte;
    logic valid_ff, nxt_valid;
    logic init_ff, nxt_init;
    logic srq_sync;
    logic take;
    logic allowed;
    logic ifc_wide;
    logic [4:0] cur_addr;

    // ------------------------------------------------------------------
    // Service request path
    // ------------------------------------------------------------------
    ibm_sync2 u_srq_sync (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .din(srq_pin),
        .dout(srq_sync)
    );

    // Devices hold the line until polled, so the level alone is logged
    ibm_srq_detect u_srq (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .srq_lvl(srq_sync),
        .enable(srq_en),
        .active(active_ff),
        .ack(irq_ack),
        .irq(srq_irq)
    );

    // ------------------------------------------------------------------
    // Request decode and role checks
    // ------------------------------------------------------------------
    assign take = req_valid && (state_ff == IBM_IDLE) && init_ff;
    assign req_ready = (state_ff == IBM_IDLE) && init_ff;
    assign ifc_wide = (req.addr_cnt == 4'h0);
    assign cur_addr = req_ff.addrs[idx_ff*5 +: 5];

    // Whether the current role permits the request
    always_comb begin
        allowed = 1'b0;
        case (req.op)
            `IBM_OP_ABORT: allowed = (active_ff || sys_ctl) && ifc_wide;
            `IBM_OP_CLEAR: allowed = active_ff;
            `IBM_OP_REMOTE: allowed = sys_ctl;
            `IBM_OP_LOCKOUT: allowed = active_ff && ifc_wide;
            `IBM_OP_LOCAL: allowed = ifc_wide ? sys_ctl : active_ff;
            `IBM_OP_TRIGGER: allowed = active_ff;
            default: allowed = 1'b0;
        endcase
        if (req.addr_cnt > `IBM_MAX_ADDR) begin
            allowed = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Sequencer next state
    // ------------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        nxt_req = req_ff;
        nxt_idx = idx_ff;
        nxt_cnt = cnt_ff;
        nxt_active = active_ff;
        nxt_ren = ren_ff;
        nxt_lockout = lockout_ff;
        nxt_err = err_ff;
        nxt_done = 1'b0;
        nxt_byte = byte_ff;
        nxt_valid = valid_ff;
        nxt_init = 1'b1;
        nxt_nac = nac_ff;
        if (irq_ack) begin
            nxt_nac = 1'b0;
        end
        if (ctl_event && !active_ff) begin
            nxt_nac = 1'b1;
        end
        if (valid_ff && out_ready) begin
            nxt_valid = 1'b0;
        end
        case (state_ff)
            IBM_IDLE: begin
                if (!init_ff) begin
                    // Power-up behaves as an abort when system controller
                    if (sys_ctl) begin
                        nxt_state = IBM_IFC;
                        nxt_cnt = '0;
                        nxt_active = 1'b1;
                        nxt_ren = 1'b1;
                    end
                end else if (take) begin
                    nxt_req = req;
                    nxt_idx = 4'h0;
                    nxt_err = !allowed;
                    if (allowed) begin
                        case (req.op)
                            `IBM_OP_ABORT: begin
                                nxt_state = IBM_IFC;
                                nxt_cnt = '0;
                                nxt_valid = 1'b0;
                                nxt_active = 1'b1;
                                if (sys_ctl) begin
                                    nxt_ren = 1'b1;
                                end
                            end
                            `IBM_OP_REMOTE: begin
                                nxt_ren = 1'b1;
                                nxt_state = ifc_wide ? IBM_IDLE : IBM_UNL;
                                nxt_done = ifc_wide;
                            end
                            `IBM_OP_LOCAL: begin
                                if (ifc_wide) begin
                                    nxt_ren = 1'b0;
                                    nxt_lockout = 1'b0;
                                    nxt_done = 1'b1;
                                end else begin
                                    nxt_state = IBM_UNL;
                                end
                            end
                            `IBM_OP_LOCKOUT: begin
                                nxt_lockout = 1'b1;
                                nxt_state = IBM_MSG;
                            end
                            default: begin
                                // Clear and trigger: universal or addressed
                                nxt_state = ifc_wide ? IBM_MSG : IBM_UNL;
                            end
                        endcase
                    end else begin
                        nxt_done = 1'b1;
                    end
                end
            end
            IBM_IFC: begin
                nxt_cnt = cnt_ff + 1'b1;
                if (cnt_ff == `IBM_IFC_W'(`IBM_IFC_CYC - 1)) begin
                    nxt_state = IBM_IDLE;
                    nxt_done = init_ff;
                end
            end
            IBM_UNL: begin
                if (!valid_ff || out_ready) begin
                    nxt_byte = '{atn: 1'b1, data: `IBM_CMD_UNL};
                    nxt_valid = 1'b1;
                    nxt_state = IBM_TALK;
                end
            end
            IBM_TALK: begin
                if (!valid_ff || out_ready) begin
                    nxt_byte = '{atn: 1'b1,
                                 data: `IBM_TALK_BASE | {3'h0, req_ff.my_addr}};
                    nxt_valid = 1'b1;
                    nxt_state = IBM_LISTEN;
                end
            end
            IBM_LISTEN: begin
                if (!valid_ff || out_ready) begin
                    nxt_byte = '{atn: 1'b1,
                                 data: `IBM_LISTEN_BASE | {3'h0, cur_addr}};
                    nxt_valid = 1'b1;
                    nxt_idx = idx_ff + 4'h1;
                    if (idx_ff + 4'h1 == req_ff.addr_cnt) begin
                        nxt_state = (req_ff.op == `IBM_OP_REMOTE) ? IBM_DATA : IBM_MSG;
                    end
                end
            end
            IBM_MSG: begin
                if (!valid_ff || out_ready) begin
                    nxt_valid = 1'b1;
                    nxt_state = IBM_DATA;
                    case (req_ff.op)
                        `IBM_OP_CLEAR: nxt_byte = '{atn: 1'b1,
                            data: (req_ff.addr_cnt == 4'h0) ? `IBM_CMD_DCL : `IBM_CMD_SDC};
                        `IBM_OP_LOCKOUT: nxt_byte = '{atn: 1'b1, data: `IBM_CMD_LLO};
                        `IBM_OP_LOCAL: nxt_byte = '{atn: 1'b1, data: `IBM_CMD_GTL};
                        default: nxt_byte = '{atn: 1'b1, data: `IBM_CMD_GET};
                    endcase
                end
            end
            IBM_DATA: begin
                // Wait for the last byte to leave, then release attention
                if (!valid_ff || out_ready) begin
                    nxt_byte.atn = 1'b0;
                    nxt_state = IBM_IDLE;
                    nxt_done = 1'b1;
                end
            end
            default: nxt_state = IBM_IDLE;
        endcase
    end

    // ------------------------------------------------------------------
    // Sequencer registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state_ff <= IBM_IDLE;
            req_ff <= '0;
            idx_ff <= 4'h0;
            cnt_ff <= '0;
            active_ff <= 1'b0;
            ren_ff <= 1'b0;
            lockout_ff <= 1'b0;
            err_ff <= 1'b0;
            done_ff <= 1'b0;
            byte_ff <= '0;
            valid_ff <= 1'b0;
            init_ff <= 1'b0;
            nac_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            req_ff <= nxt_req;
            idx_ff <= nxt_idx;
            cnt_ff <= nxt_cnt;
            active_ff <= nxt_active;
            ren_ff <= nxt_ren;
            lockout_ff <= nxt_lockout;
            err_ff <= nxt_err;
            done_ff <= nxt_done;
            byte_ff <= nxt_byte;
            valid_ff <= nxt_valid;
            init_ff <= nxt_init;
            nac_ff <= nxt_nac;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign out_byte = byte_ff;
    assign out_valid = valid_ff;
    assign ifc_o = (state_ff == IBM_IFC);
    assign ren_o = ren_ff;
    assign nac_irq = nac_ff;
    assign status = '{busy: (state_ff != IBM_IDLE), done: done_ff, role_err: err_ff,
                      active_ctl: active_ff, lockout: lockout_ff, remote: ren_ff,
                      srq_irq: srq_irq};
endmodule : ibm_bus_mgmt

// file: logic/ibm_consts.svh
// Constants for the instrument bus management block: command bytes,
// command codes, address limits and timing counts.
// Assumes a 125 MHz system clock.
`ifndef IBM_CONSTS_SVH
`define IBM_CONSTS_SVH

// ----------------------------------------------------------------------
// Bus command bytes sent with attention asserted
// ----------------------------------------------------------------------
`define IBM_CMD_UNL 8'h3F
`define IBM_CMD_DCL 8'h14
`define IBM_CMD_SDC 8'h04
`define IBM_CMD_LLO 8'h11
`define IBM_CMD_GTL 8'h01
`define IBM_CMD_GET 8'h08
`define IBM_TALK_BASE 8'h40
`define IBM_LISTEN_BASE 8'h20
`define IBM_ADDR_MASK 8'h1F

// ----------------------------------------------------------------------
// Host request codes
// ----------------------------------------------------------------------
`define IBM_OP_NONE 3'h0
`define IBM_OP_ABORT 3'h1
`define IBM_OP_CLEAR 3'h2
`define IBM_OP_REMOTE 3'h3
`define IBM_OP_LOCKOUT 3'h4
`define IBM_OP_LOCAL 3'h5
`define IBM_OP_TRIGGER 3'h6

// ----------------------------------------------------------------------
// Sizes and timing
// ----------------------------------------------------------------------
`define IBM_MAX_ADDR 4'h8
`define IBM_IFC_NS 100
`define IBM_CLK_NS 8
`define IBM_IFC_CYC ((`IBM_IFC_NS + `IBM_CLK_NS - 1) / `IBM_CLK_NS)
`define IBM_IFC_W 5

`endif

// file: logic/ibm_pkg.sv
// Types for the instrument bus management block.
// Assumes ibm_consts.svh is on the include path.
`include "ibm_consts.svh"

package ibm_pkg;

    // Host request as it is taken
    typedef struct packed {
        logic [2:0] op;
        logic [3:0] addr_cnt;
        logic [39:0] addrs;
        logic [4:0] my_addr;
    } ibm_req_t;

    // Status shown to the host
    typedef struct packed {
        logic busy;
        logic done;
        logic role_err;
        logic active_ctl;
        logic lockout;
        logic remote;
        logic srq_irq;
    } ibm_stat_t;

    // One byte handed to the byte handshake
    typedef struct packed {
        logic atn;
        logic [7:0] data;
    } ibm_byte_t;

endpackage : ibm_pkg

// file: logic/ibm_sync2.sv
// Two flip-flop synchroniser for a bus input line.
// Assumes the input is asynchronous to clk_sys.
`timescale 1ns/10ps

module ibm_sync2 (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic din,
    output logic dout
);
    logic meta_ff;
    logic nxt_meta;
    logic sync_ff;
    logic nxt_sync;

    // Next values of the chain
    always_comb begin
        nxt_meta = din;
        nxt_sync = meta_ff;
    end

    // Registers of the chain
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
        end else begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
        end
    end

    assign dout = sync_ff;
endmodule : ibm_sync2

// file: logic/ibm_srq_detect.sv
// Level-sensitive service request detector with enable and latch.
// Assumes srq_lvl is already synchronised to clk_sys.
`timescale 1ns/10ps

module ibm_srq_detect (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic srq_lvl,
    input wire logic enable,
    input wire logic active,
    input wire logic ack,
    output logic irq
);
    logic irq_ff;
    logic nxt_irq;

    // Sample the level; once logged, hold until the host acknowledges
    always_comb begin
        nxt_irq = irq_ff;
        if (ack) begin
            nxt_irq = 1'b0;
        end
        if (srq_lvl && enable && active) begin
            nxt_irq = 1'b1;
        end
    end

    // Interrupt flag register
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= nxt_irq;
        end
    end

    assign irq = irq_ff;
endmodule : ibm_srq_detect

// file: bench/ibm_bus_mgmt_checker.sv
// Concurrent checks on the ports of the bus management block.
// Assumes it is bound to ibm_bus_mgmt and that clk_sys runs at 125 MHz.
`timescale 1ns/10ps
`include "ibm_consts.svh"

module ibm_bus_mgmt_checker
    import ibm_pkg::*;
(
    input logic clk_sys,
    input logic arst_n,
    input logic req_valid,
    input logic req_ready,
    input ibm_req_t req,
    input logic sys_ctl,
    input logic srq_en,
    input logic ctl_event,
    input ibm_byte_t out_byte,
    input logic out_valid,
    input logic out_ready,
    input logic ifc_o,
    input logic ren_o,
    input logic srq_pin,
    input ibm_stat_t status,
    input logic srq_irq,
    input logic nac_irq
);
    logic [4:0] ifc_cnt_ff;
    logic [4:0] nxt_ifc_cnt;
    logic take;

    // ----------------
    // Helper logic
    // ----------------
    // Request accepted at this edge
    assign take = req_valid && req_ready;

    // Interface clear pulse length
    always_comb begin
        nxt_ifc_cnt = ifc_o ? ifc_cnt_ff + 5'h1 : 5'h0;
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ifc_cnt_ff <= 5'h0;
        end else begin
            ifc_cnt_ff <= nxt_ifc_cnt;
        end
    end

    // ----------------
    // Assertions
    // ----------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    property p_ifc_len;
        $fell(ifc_o) |-> ifc_cnt_ff == `IBM_IFC_CYC;
    endproperty
    a_ifc_len: assert property (p_ifc_len) else $error("ifc pulse length wrong");

    property p_abort_regain;
        take && req.op == `IBM_OP_ABORT && sys_ctl && req.addr_cnt == 4'h0 |=>
            ##[0:1] ifc_o ##[12:14] (!ifc_o && status.active_ctl && ren_o);
    endproperty
    a_abort_regain: assert property (p_abort_regain) else $error("abort outcome wrong");

    property p_abort_addr;
        take && req.op == `IBM_OP_ABORT && req.addr_cnt != 4'h0 |=>
            status.role_err && status.done && !ifc_o;
    endproperty
    a_abort_addr: assert property (p_abort_addr) else $error("addressed abort taken");

    property p_remote_sys;
        take && req.op == `IBM_OP_REMOTE && !sys_ctl |=> status.role_err && !out_valid;
    endproperty
    a_remote_sys: assert property (p_remote_sys) else $error("remote not refused");

    property p_clear_act;
        take && req.op == `IBM_OP_CLEAR && !status.active_ctl |=> status.role_err && !out_valid;
    endproperty
    a_clear_act: assert property (p_clear_act) else $error("clear not refused");

    property p_llo_role;
        take && req.op == `IBM_OP_LOCKOUT && (!status.active_ctl || req.addr_cnt != 4'h0)
            |=> status.role_err && !out_valid;
    endproperty
    a_llo_role: assert property (p_llo_role) else $error("lockout not refused");

    property p_lock_keep;
        status.lockout && ifc_o |=> status.lockout;
    endproperty
    a_lock_keep: assert property (p_lock_keep) else $error("lockout lost in abort");

    property p_atn;
        out_valid |-> out_byte.atn;
    endproperty
    a_atn: assert property (p_atn) else $error("command byte without atn");

    property p_hold;
        out_valid && !out_ready |=> out_valid && $stable(out_byte);
    endproperty
    a_hold: assert property (p_hold) else $error("byte changed before ready");

    property p_srq_lvl;
        (!srq_pin)[*4] ##0 !srq_irq |=> !srq_irq;
    endproperty
    a_srq_lvl: assert property (p_srq_lvl) else $error("irq without request level");

    property p_srq_set;
        (srq_pin && srq_en && status.active_ctl)[*5] |-> srq_irq;
    endproperty
    a_srq_set: assert property (p_srq_set) else $error("service irq missing");

    property p_nac;
        ctl_event && !status.active_ctl |=> nac_irq;
    endproperty
    a_nac: assert property (p_nac) else $error("non-active irq missing");
endmodule : ibm_bus_mgmt_checker

bind ibm_bus_mgmt ibm_bus_mgmt_checker u_chk (.clk_sys(clk_sys), .arst_n(arst_n),
    .req_valid(req_valid), .req_ready(req_ready), .req(req), .sys_ctl(sys_ctl),
    .srq_en(srq_en), .ctl_event(ctl_event), .out_byte(out_byte), .out_valid(out_valid),
    .out_ready(out_ready), .ifc_o(ifc_o), .ren_o(ren_o), .srq_pin(srq_pin),
    .status(status), .srq_irq(srq_irq), .nac_irq(nac_irq));

// file: bench/ibm_instr_model.sv
// Behavioural instrument on the far side of the bus.
// Assumes the testbench reads rx_q and remote_ff by path.
`timescale 1ns/10ps
`include "ibm_consts.svh"

module ibm_instr_model
    import ibm_pkg::*;
#(
    parameter logic [4:0] DEV_ADDR = 5'h01
)
(
    input logic clk_sys,
    input logic arst_n,
    input ibm_byte_t out_byte,
    input logic out_valid,
    output logic out_ready,
    input logic ren_o,
    output logic srq_pin,
    input logic stall,
    input logic need_srv,
    input logic local_key
);
    ibm_byte_t rx_q[$];
    logic remote_ff;
    logic lockout_ff;
    logic [1:0] slow_ff;

    // Slow acceptance takes one byte in four cycles
    assign out_ready = !stall || slow_ff == 2'h3;
    // Request line follows the device's need, released once served
    assign srq_pin = need_srv;

    // Byte log and front-panel state
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            remote_ff <= 1'b0;
            lockout_ff <= 1'b0;
            slow_ff <= 2'h0;
        end else begin
            slow_ff <= slow_ff + 2'h1;
            if (out_valid && out_ready) begin
                rx_q.push_back(out_byte);
                if (ren_o && out_byte.data == (`IBM_LISTEN_BASE | {3'h0, DEV_ADDR})) begin
                    remote_ff <= 1'b1;
                end
                if (out_byte.data == `IBM_CMD_LLO) begin
                    lockout_ff <= 1'b1;
                end
            end
            if (!ren_o) begin
                remote_ff <= 1'b0;
                lockout_ff <= 1'b0;
            end else if (local_key && !lockout_ff) begin
                remote_ff <= 1'b0;
            end
        end
    end
endmodule : ibm_instr_model

// file: bench/testbench.sv
// Self-checking bench for the bus management block.
// Assumes package, design, checker and model compile first.
`timescale 1ns/10ps
`include "ibm_consts.svh"

module testbench
    import ibm_pkg::*;
;
    localparam logic [4:0] MY = 5'h0A;
    logic clk_sys, arst_n, req_valid, req_ready, sys_ctl, srq_en, irq_ack, ctl_event;
    logic out_valid, out_ready, ifc_o, ren_o, srq_pin, srq_irq, nac_irq;
    logic stall, need_srv, local_key, rerr;
    ibm_req_t req;
    ibm_byte_t out_byte;
    ibm_stat_t status;
    logic [7:0] exp_q[$];
    int err_count, tests_run, cyc;

    ibm_bus_mgmt dut (.clk_sys(clk_sys), .arst_n(arst_n), .req_valid(req_valid),
        .req_ready(req_ready), .req(req), .sys_ctl(sys_ctl), .srq_en(srq_en),
        .irq_ack(irq_ack), .ctl_event(ctl_event), .data_done(1'b0), .out_byte(out_byte),
        .out_valid(out_valid), .out_ready(out_ready), .ifc_o(ifc_o), .ren_o(ren_o),
        .srq_pin(srq_pin), .status(status), .srq_irq(srq_irq), .nac_irq(nac_irq));

    ibm_instr_model u_inst (.clk_sys(clk_sys), .arst_n(arst_n), .out_byte(out_byte),
        .out_valid(out_valid), .out_ready(out_ready), .ren_o(ren_o), .srq_pin(srq_pin),
        .stall(stall), .need_srv(need_srv), .local_key(local_key));

    // ----------------
    // Shared tasks
    // ----------------
    task automatic chk1(input string nm, input logic e, input logic g);
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %s expected %b seen %b", nm, e, g);
        end
    endtask : chk1

    task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk8

    // Issue one request and wait for its done pulse
    task automatic issue(input logic [2:0] op, input logic [3:0] n, input logic [39:0] ad);
        int w = 0;
        u_inst.rx_q.delete();
        @(negedge clk_sys);
        while (req_ready !== 1'b1 && w < 400) begin
            @(negedge clk_sys);
            w++;
        end
        @(posedge clk_sys);
        req_valid <= 1'b1;
        req <= '{op, n, ad, MY};
        @(posedge clk_sys);
        req_valid <= 1'b0;
        @(negedge clk_sys);
        while (status.done !== 1'b1 && w < 800) begin
            @(negedge clk_sys);
            w++;
        end
        chk1("done", 1'b1, status.done);
        rerr = status.role_err;
    endtask : issue

    // Bytes the instrument took against exp_q
    task automatic chk_bytes;
        chk8("byte count", 8'(exp_q.size()), 8'(u_inst.rx_q.size()));
        foreach (exp_q[i]) begin
            chk8("bus byte", exp_q[i], u_inst.rx_q[i].data);
        end
    endtask : chk_bytes

    // One-cycle strobe: bit 2 event, bit 1 acknowledge, bit 0 local key
    task automatic pulse(input logic [2:0] m);
        @(posedge clk_sys);
        {ctl_event, irq_ack, local_key} <= m;
        @(posedge clk_sys);
        {ctl_event, irq_ack, local_key} <= 3'h0;
        repeat (3) @(negedge clk_sys);
    endtask : pulse

    // ----------------
    // Scenarios
    // ----------------
    task automatic t_refuse;
        exp_q = {};
        for (int k = 1; k <= 6; k++) begin
            issue(3'(k), 4'h0, 40'h0);
            chk1("role error", 1'b1, rerr);
            chk_bytes();
        end
        pulse(3'h4);
        chk1("nac irq", 1'b1, nac_irq);
        pulse(3'h2);
        chk1("nac irq", 1'b0, nac_irq);
    endtask : t_refuse

    task automatic t_abort;
        @(posedge clk_sys);
        sys_ctl <= 1'b1;
        issue(`IBM_OP_ABORT, 4'h1, 40'h1);
        chk1("role error", 1'b1, rerr);
        issue(`IBM_OP_ABORT, 4'h0, 40'h0);
        chk1("role error", 1'b0, rerr);
        chk1("active", 1'b1, status.active_ctl);
        chk1("remote", 1'b1, ren_o);
    endtask : t_abort

    task automatic t_addressed;
        logic [2:0] ops[4] = '{`IBM_OP_CLEAR, `IBM_OP_TRIGGER, `IBM_OP_LOCAL, `IBM_OP_REMOTE};
        logic [7:0] msg[3] = '{`IBM_CMD_SDC, `IBM_CMD_GET, `IBM_CMD_GTL};
        logic [39:0] ad;
        stall <= 1'b1;
        foreach (ops[j]) begin
            exp_q = '{`IBM_CMD_UNL, `IBM_TALK_BASE | {3'h0, MY}, 8'h21, 8'h23};
            if (j < 3) exp_q.push_back(msg[j]);
            issue(ops[j], 4'h2, {30'h0, 5'h03, 5'h01});
            chk1("role error", 1'b0, rerr);
            chk_bytes();
        end
        chk1("device remote", 1'b1, u_inst.remote_ff);
        exp_q = '{`IBM_CMD_UNL, `IBM_TALK_BASE | {3'h0, MY}};
        for (int k = 0; k < 8; k++) begin
            ad[5*k+:5] = 5'(k + 1);
            exp_q.push_back(`IBM_LISTEN_BASE | 8'(k + 1));
        end
        exp_q.push_back(`IBM_CMD_GET);
        issue(`IBM_OP_TRIGGER, 4'h8, ad);
        chk_bytes();
        issue(`IBM_OP_CLEAR, 4'h9, ad);
        chk1("role error", 1'b1, rerr);
        stall <= 1'b0;
    endtask : t_addressed

    task automatic t_universal;
        logic [2:0] ops[3] = '{`IBM_OP_CLEAR, `IBM_OP_TRIGGER, `IBM_OP_LOCKOUT};
        logic [7:0] msg[3] = '{`IBM_CMD_DCL, `IBM_CMD_GET, `IBM_CMD_LLO};
        foreach (ops[j]) begin
            exp_q = '{msg[j]};
            issue(ops[j], 4'h0, 40'h0);
            chk_bytes();
        end
        chk1("lockout", 1'b1, status.lockout);
        issue(`IBM_OP_LOCKOUT, 4'h1, 40'h1);
        chk1("role error", 1'b1, rerr);
    endtask : t_universal

    task automatic t_lock_abort;
        issue(`IBM_OP_ABORT, 4'h0, 40'h0);
        chk1("lockout", 1'b1, status.lockout);
        pulse(3'h1);
        chk1("device remote", 1'b1, u_inst.remote_ff);
        exp_q = {};
        issue(`IBM_OP_LOCAL, 4'h0, 40'h0);
        chk_bytes();
        chk1("lockout", 1'b0, status.lockout);
        chk1("remote", 1'b0, ren_o);
        issue(`IBM_OP_REMOTE, 4'h0, 40'h0);
        chk1("remote", 1'b1, ren_o);
    endtask : t_lock_abort

    task automatic t_srq;
        need_srv <= 1'b1;
        repeat (8) @(negedge clk_sys);
        chk1("srq irq", 1'b0, srq_irq);
        @(posedge clk_sys);
        srq_en <= 1'b1;
        repeat (6) @(negedge clk_sys);
        chk1("srq irq", 1'b1, srq_irq);
        chk1("srq status", 1'b1, status.srq_irq);
        need_srv <= 1'b0;
        repeat (4) @(negedge clk_sys);
        pulse(3'h2);
        chk1("srq irq", 1'b0, srq_irq);
    endtask : t_srq

    task automatic conclude;
        $display("checks %0d errors %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : conclude

    // ----------------
    // Clock, timeout and main sequence
    // ----------------
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            conclude();
        end
    end

    initial begin
        {arst_n, req_valid, sys_ctl, srq_en, irq_ack, ctl_event} = 6'h00;
        {stall, need_srv, local_key} = 3'h0;
        req = '0;
        repeat (12) @(posedge clk_sys);
        arst_n <= 1'b1;
        t_refuse();
        t_abort();
        t_addressed();
        t_universal();
        t_lock_abort();
        t_srq();
        conclude();
    end
endmodule : testbench
